// ---- hdl/mpg_top.sv ----
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mpg_cfg.svh"
// Contract
// - blocks of two or more data+prbs rows
// - up to 511 blocks, count reported back
// - selectable output polarity
// - mixed prbs stages 7..31, period 2^n-1
// - prbs7 scramble only in enabled areas
// - scramble off stops scrambling at once
// - per-area enables, set-all and clear-all
// - first row data never scrambled
// - prbs restart or continue across blocks
// - pam4 only with combined channels
// - pam4 prbs stages 7..31, period 2^n-1
// - independent prbs invert switch, pam4 only
// - per-lane programmable prbs seed
// - optional gray mapping of symbols
// - pam4 data from loaded pattern, length reported
// - loading indicator during memory transfer
module mpg_top #(
  parameter int MEM_WORDS = 64
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire mpg_pkg::mpg_trans_t htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic chan_combined,
  output logic loading,
  output logic lane_msb,
  output logic lane_lsb
);
  import mpg_pkg::*;
  localparam int PW = $clog2(MEM_WORDS * 32);
  if (MEM_WORDS < 2 || (MEM_WORDS & (MEM_WORDS - 1)) != 0) begin : g_bad
    $error("MEM_WORDS must be a power of two, at least 2");
  end

  ////////////////////////////////////////////////////////////////////
  // helpers
  // feedback tap of the selected stage count
  function automatic logic [30:0] lfsr_step(input logic [30:0] s, input logic [2:0] sel);
    logic fb;
    fb = 1'b0;
    case (sel)
      3'd0: fb = s[6] ^ s[5];
      3'd1: fb = s[8] ^ s[4];
      3'd2: fb = s[9] ^ s[6];
      3'd3: fb = s[10] ^ s[8];
      3'd4: fb = s[14] ^ s[13];
      3'd5: fb = s[19] ^ s[16];
      3'd6: fb = s[22] ^ s[17];
      default: fb = s[30] ^ s[27];
    endcase
    return {s[29:0], fb};
  endfunction : lfsr_step

  // output tap sits at stage n-1
  function automatic logic lfsr_out(input logic [30:0] s, input logic [2:0] sel);
    logic b;
    b = 1'b0;
    case (sel)
      3'd0: b = s[6];
      3'd1: b = s[8];
      3'd2: b = s[9];
      3'd3: b = s[10];
      3'd4: b = s[14];
      3'd5: b = s[19];
      3'd6: b = s[22];
      default: b = s[30];
    endcase
    return b;
  endfunction : lfsr_out

  ////////////////////////////////////////////////////////////////////
  // ahb-lite slave
  logic [31:0] ctrl_r;
  logic [31:0] geom_r;
  logic [15:0] scra_r;
  logic [30:0] seed_r [4];
  logic [31:0] mem [MEM_WORDS];
  logic [7:0] addr_r;
  logic wr_r;
  logic [15:0] len_r;
  logic loading_r;
  logic [15:0] wptr_r;
  logic comb_m_r;
  logic comb_s_r;
  mpg_gen_t st_r;

  wire acc = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1; // zero wait states, answer is always OKAY
  assign hresp = 1'b0;
  assign loading = loading_r;

  // address phase capture; read data prepared here so it leaves a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= 8'h00;
      wr_r <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_r <= acc & hwrite;
      addr_r <= haddr[7:0];
      if (acc && !hwrite) begin
        if (haddr[7:0] == `MPG_CTRL) hrdata <= ctrl_r;
        else if (haddr[7:0] == `MPG_SCRA) hrdata <= {16'h0000, scra_r};
        else if (haddr[7:0] == `MPG_GEOM) hrdata <= geom_r;
        else if (haddr[7:4] == 4'h1 && haddr[1:0] == 2'b00) hrdata <= {1'b0, seed_r[haddr[3:2]]};
        else if (haddr[7:0] == `MPG_LOAD) hrdata <= {31'h0, loading_r};
        else if (haddr[7:0] == `MPG_STAT) hrdata <= {len_r, 3'b000, geom_r[`MPG_G_BLKS], st_r, comb_s_r, loading_r};
        else hrdata <= 32'h0000_0000; // unmapped reads zero
      end
    end
  end

  // area enables, bulk set and clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `MPG_CTRL_RST;
      geom_r <= `MPG_GEOM_RST;
      scra_r <= 16'h0000;
      for (int i = 0; i < 4; i++) seed_r[i] <= `MPG_SEED_RST;
    end else if (wr_r) begin
      if (addr_r == `MPG_CTRL) ctrl_r <= hwdata;
      else if (addr_r == `MPG_SCRA) scra_r <= hwdata[15:0];
      else if (addr_r == `MPG_SCMD && hwdata[0]) scra_r <= 16'hFFFF;
      else if (addr_r == `MPG_SCMD && hwdata[1]) scra_r <= 16'h0000;
      else if (addr_r == `MPG_GEOM) geom_r <= hwdata;
      else if (addr_r[7:4] == 4'h1) seed_r[addr_r[3:2]] <= hwdata[30:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loading_r <= 1'b0;
      wptr_r <= 16'h0000;
      len_r <= 16'h0000;
    end else if (wr_r && addr_r == `MPG_LOAD) begin
      loading_r <= hwdata[0];
      if (hwdata[0]) begin
        wptr_r <= 16'h0000;
        len_r <= 16'h0000;
      end
    end else if (wr_r && addr_r == `MPG_DATA && loading_r && wptr_r < 16'(MEM_WORDS)) begin
      wptr_r <= wptr_r + 16'h0001;
      len_r <= len_r + 16'h0001; // words loaded
    end
  end

  // pattern memory, no reset so it maps onto ram
  always_ff @(posedge hclk) begin
    if (wr_r && addr_r == `MPG_DATA && loading_r && wptr_r < 16'(MEM_WORDS)) begin
      mem[wptr_r[PW-6:0]] <= hwdata;
    end
  end

  // combine pin crosses in from the other module
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comb_m_r <= 1'b0;
      comb_s_r <= 1'b0;
    end else begin
      comb_m_r <= chan_combined;
      comb_s_r <= comb_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pattern engine
  logic [30:0] lfsr_r;
  logic [6:0] scr_r;
  logic [7:0] cnt_r;
  logic [3:0] row_r;
  logic [8:0] blk_r;
  logic [PW-1:0] mp_r;
  logic [1:0] sym;
  logic mix_bit;
  logic scr_apply;

  wire [2:0] stg = ctrl_r[`MPG_C_STG];
  wire pam_en = ctrl_r[`MPG_C_PAM] & comb_s_r;
  wire pol = ctrl_r[`MPG_C_POL];
  wire [30:0] seed_sel = seed_r[ctrl_r[`MPG_C_LANE]];
  wire [30:0] seed_eff = (seed_sel == 31'h0) ? 31'h1 : seed_sel; // all-zero locks up
  wire [3:0] rows_eff = (geom_r[`MPG_G_ROWS] < `MPG_MIN_ROWS) ? `MPG_MIN_ROWS
                        : geom_r[`MPG_G_ROWS];
  wire [8:0] blks_eff = (geom_r[`MPG_G_BLKS] == 9'h0) ? 9'h1 : geom_r[`MPG_G_BLKS];
  // one bit wider than the pointer so a full memory does not wrap the length to zero
  wire [PW:0] mlen = (PW+1)'({len_r, 5'h00});
  wire seg_end_d = (cnt_r + 8'h01 >= geom_r[`MPG_G_DLEN]);
  wire seg_end_p = (cnt_r + 8'h01 >= geom_r[`MPG_G_PLEN]);
  wire row_last = (row_r + 4'h1 >= rows_eff);
  wire blk_last = (blk_r + 9'h001 >= blks_eff);
  wire blk_end = (st_r == G_PRBS) && seg_end_p && row_last;
  wire [30:0] l1 = lfsr_step(lfsr_r, stg);
  wire [PW:0] mp1w = {1'b0, mp_r} + (PW+1)'(1);
  wire [PW:0] mp2w = {1'b0, mp_r} + (PW+1)'(2);

  // mixed bit and area scramble
  always_comb begin
    mix_bit = (st_r == G_DATA) ? mem[mp_r[PW-1:5]][mp_r[4:0]] : lfsr_out(lfsr_r, stg);
    scr_apply = ctrl_r[`MPG_C_SCR] && scra_r[{row_r[2:0], st_r == G_PRBS}]
                && (st_r == G_DATA || st_r == G_PRBS)
                && !(row_r == 4'h0 && st_r == G_DATA);
  end

  // pam4 symbol, msb first in time for prbs; loaded data puts the earlier bit in the lsb
  always_comb begin
    if (ctrl_r[`MPG_C_RAWD]) begin
      sym = {mem[mp_r[PW-1:5]][mp_r[4:0] + 5'd1], mem[mp_r[PW-1:5]][mp_r[4:0]]};
    end else begin
      sym = {lfsr_out(lfsr_r, stg), lfsr_out(l1, stg)} ^ {2{ctrl_r[`MPG_C_INV]}};
    end
    if (ctrl_r[`MPG_C_GRAY]) sym = {sym[1], sym[1] ^ sym[0]};
  end

  // sequencer; row data pointer keeps running through the blocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= G_IDLE;
      cnt_r <= 8'h00;
      row_r <= 4'h0;
      blk_r <= 9'h000;
      mp_r <= '0;
    end else if (loading_r || !ctrl_r[`MPG_C_RUN]) begin
      // park and restart from the top
      st_r <= G_IDLE;
      cnt_r <= 8'h00;
      row_r <= 4'h0;
      blk_r <= 9'h000;
      mp_r <= '0;
    end else begin
      case (st_r)
        G_IDLE: st_r <= pam_en ? G_PAM : G_DATA;
        G_DATA: begin
          mp_r <= (mp1w >= mlen) ? '0 : mp1w[PW-1:0];
          cnt_r <= seg_end_d ? 8'h00 : cnt_r + 8'h01;
          if (seg_end_d) st_r <= G_PRBS;
        end
        G_PRBS: begin
          cnt_r <= seg_end_p ? 8'h00 : cnt_r + 8'h01;
          if (seg_end_p) begin
            st_r <= G_DATA;
            row_r <= row_last ? 4'h0 : row_r + 4'h1;
            if (row_last) blk_r <= blk_last ? 9'h000 : blk_r + 9'h001;
            if (row_last && blk_last) mp_r <= '0;
          end
        end
        default: begin
          mp_r <= (mp2w >= mlen) ? '0 : mp2w[PW-1:0];
          if (!pam_en) st_r <= G_IDLE;
        end
      endcase
    end
  end

  // prbs register: one step per prbs bit of the mixed stream, held during data, two per pam4 symbol
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lfsr_r <= `MPG_SEED_RST;
    end else if (st_r == G_IDLE) begin
      lfsr_r <= seed_eff;
    end else if (st_r == G_PRBS) begin
      lfsr_r <= (blk_end && !ctrl_r[`MPG_C_CONT]) ? seed_eff : l1;
    end else if (st_r == G_PAM) begin
      lfsr_r <= lfsr_step(l1, stg);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) scr_r <= `MPG_SCR_SEED;
    else if (st_r == G_IDLE) scr_r <= `MPG_SCR_SEED;
    else if (st_r != G_PAM) scr_r <= {scr_r[5:0], scr_r[6] ^ scr_r[5]};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lane_msb <= 1'b0;
      lane_lsb <= 1'b0;
    end else if (st_r == G_PAM) begin
      lane_msb <= sym[1] ^ pol;
      lane_lsb <= sym[0] ^ pol;
    end else if (st_r == G_IDLE) begin
      lane_msb <= pol;
      lane_lsb <= pol;
    end else begin
      lane_msb <= pol;
      lane_lsb <= mix_bit ^ (scr_apply & scr_r[6]) ^ pol;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  a_load_flag_on: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_r && addr_r == `MPG_LOAD && hwdata[0] |=> loading && loading_r)
    else $error("loading flag not raised");
  a_load_idle_out: assert property (@(posedge hclk) disable iff (!hresetn)
    loading_r ##1 loading_r |=> st_r == G_IDLE && lane_lsb == $past(pol, 1))
    else $error("stream not idle while loading");
  a_first_row_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r == G_DATA && row_r == 4'h0 |=> lane_lsb == $past(mix_bit ^ pol))
    else $error("first row data scrambled");
  a_scr_off_now: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_r[`MPG_C_SCR] && (st_r == G_DATA || st_r == G_PRBS)
    |=> lane_lsb == $past(mix_bit ^ pol))
    else $error("scramble active while off");
  a_pam_needs_comb: assert property (@(posedge hclk) disable iff (!hresetn)
    !comb_s_r ##1 !comb_s_r |-> st_r != G_PAM)
    else $error("pam4 without combined channels");
  a_rows_at_least: assert property (@(posedge hclk) disable iff (!hresetn)
    blk_end && !loading_r && ctrl_r[`MPG_C_RUN] |-> row_r >= 4'h1)
    else $error("block with fewer than two rows");
  a_blk_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    blk_r < `MPG_MAX_BLKS)
    else $error("block counter past limit");
  sequence s_pam_gray;
    st_r == G_PAM && ctrl_r[`MPG_C_GRAY] && !ctrl_r[`MPG_C_RAWD];
  endsequence
  a_gray_map: assert property (@(posedge hclk) disable iff (!hresetn)
    s_pam_gray |=> (lane_msb ^ lane_lsb) == $past(lfsr_out(l1, stg) ^ ctrl_r[`MPG_C_INV]))
    else $error("gray mapping wrong");
  a_restart_seed: assert property (@(posedge hclk) disable iff (!hresetn)
    blk_end && !ctrl_r[`MPG_C_CONT] && ctrl_r[`MPG_C_RUN] && !loading_r
    |=> lfsr_r == $past(seed_eff))
    else $error("prbs not restarted at block end");
endmodule : mpg_top
`default_nettype wire

// ---- hdl/mpg_cfg.svh ----
`ifndef MPG_CFG_SVH
`define MPG_CFG_SVH
// register byte offsets
`define MPG_CTRL 8'h00
`define MPG_SCRA 8'h04
`define MPG_SCMD 8'h08
`define MPG_GEOM 8'h0C
`define MPG_SEED0 8'h10
`define MPG_LOAD 8'h20
`define MPG_DATA 8'h24
`define MPG_STAT 8'h28
// control field positions
`define MPG_C_PAM 0
`define MPG_C_SCR 1
`define MPG_C_CONT 2
`define MPG_C_POL 3
`define MPG_C_INV 4
`define MPG_C_GRAY 5
`define MPG_C_RAWD 6
`define MPG_C_RUN 7
`define MPG_C_STG 10:8
`define MPG_C_LANE 13:12
// geometry fields
`define MPG_G_DLEN 7:0
`define MPG_G_PLEN 15:8
`define MPG_G_ROWS 19:16
`define MPG_G_BLKS 28:20
// reset values and limits
`define MPG_CTRL_RST 32'h0000_0000
`define MPG_GEOM_RST 32'h0012_0808
`define MPG_SEED_RST 31'h7FFF_FFFF
`define MPG_SCR_SEED 7'h7F
`define MPG_MIN_ROWS 4'h2
`define MPG_MAX_BLKS 9'h1FF
`endif

// ---- hdl/mpg_pkg.sv ----
package mpg_pkg;
  typedef logic [1:0] mpg_trans_t;
  // generator states, gray-coded along idle-data-prbs
  typedef enum logic [1:0] {
    G_IDLE = 2'b00,
    G_DATA = 2'b01,
    G_PRBS = 2'b11,
    G_PAM = 2'b10
  } mpg_gen_t;
endpackage : mpg_pkg

// ---- tb/mpg_rx_model.sv ----
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// far-side receiver: samples both lanes the way an error detector front end would
module mpg_rx_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic lane_msb,
  input wire logic lane_lsb,
  input wire logic arm,
  output logic [1:0] sym,
  output logic [7:0] cap,
  output logic cap_done
);
  logic [3:0] cnt_r;
  // symbol register, msb lane carries the earlier bit of prbs symbols, the later bit of loaded data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sym <= 2'h0;
    end else begin
      sym <= {lane_msb, lane_lsb};
    end
  end
  // byte capture aligns on the first one seen once armed, so the pattern must start with a one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 4'h0;
      cap <= 8'h00;
    end else if (!arm) begin
      cnt_r <= 4'h0;
    end else if (cnt_r != 4'h8 && (cnt_r != 4'h0 || lane_lsb)) begin
      cap <= {lane_lsb, cap[7:1]}; // first bit ends at bit 0
      cnt_r <= cnt_r + 4'h1;
    end
  end
  assign cap_done = (cnt_r == 4'h8);
endmodule : mpg_rx_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mpg_cfg.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import mpg_pkg::*;
  logic hclk = 1'h0;
  logic hresetn, hsel, hwrite, chan_combined, arm, hreadyout, hresp, loading;
  logic lane_msb, lane_lsb, cap_done;
  logic [31:0] haddr, hwdata, hrdata, rv;
  mpg_trans_t htrans;
  logic [2:0] hsize;
  logic [1:0] sym;
  logic [7:0] cap;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  always #12.5 hclk = ~hclk;
  mpg_top #(.MEM_WORDS(64)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .chan_combined(chan_combined),
    .loading(loading), .lane_msb(lane_msb), .lane_lsb(lane_lsb));
  mpg_rx_model rx (.hclk(hclk), .hresetn(hresetn), .lane_msb(lane_msb), .lane_lsb(lane_lsb),
    .arm(arm), .sym(sym), .cap(cap), .cap_done(cap_done));
  ////////////////////////////////////////////////////////////////////////////////
  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      final_report();
    end
  end
  // single ahb-lite transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rv = hrdata;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0000_0000);
    `CHK(rv, e)
    `CHK(hresp, 1'h0)
  endtask : rd
  // pattern memory transfer with the indicator watched on both sides
  task automatic load(input logic [31:0] w, input int n);
    bus(1'h1, `MPG_LOAD, 32'h0000_0001);
    @(posedge hclk);
    `CHK(loading, 1'h1)
    for (int i = 0; i < n; i++) bus(1'h1, `MPG_DATA, w);
    bus(1'h0, `MPG_STAT, 32'h0000_0000);
    `CHK(rv[0], 1'h1)
    bus(1'h1, `MPG_LOAD, 32'h0000_0000);
    @(posedge hclk);
    `CHK(loading, 1'h0)
    bus(1'h1, `MPG_DATA, w);
    bus(1'h0, `MPG_STAT, 32'h0000_0000);
    `CHK(rv[31:16], 16'(n))
  endtask : load
  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    rd(`MPG_CTRL, `MPG_CTRL_RST);
    rd(`MPG_GEOM, `MPG_GEOM_RST);
    for (int i = 0; i < 4; i++) rd(`MPG_SEED0 + 8'(4 * i), {1'h0, `MPG_SEED_RST});
    bus(1'h1, 8'h14, 32'h0000_1234);
    rd(8'h14, 32'h0000_1234);
    bus(1'h1, 8'h30, 32'h0000_FFFF);
    rd(8'h30, 32'h0000_0000);
    bus(1'h1, `MPG_SCMD, 32'h0000_0002);
    rd(`MPG_SCRA, 32'h0000_0000);
    bus(1'h1, `MPG_SCRA, 32'h0000_0004);
    rd(`MPG_SCRA, 32'h0000_0004);
    bus(1'h1, `MPG_SCMD, 32'h0000_0001);
    rd(`MPG_SCRA, 32'h0000_FFFF);
    rd(`MPG_SCMD, 32'h0000_0000);
  endtask : t_regs
  task t_blocks;
    bus(1'h1, `MPG_GEOM, 32'h1FF2_0808);
    bus(1'h0, `MPG_STAT, 32'h0000_0000);
    `CHK(rv[12:4], `MPG_MAX_BLKS)
  endtask : t_blocks
  // every area scrambled, yet the first row's data must arrive untouched
  task t_mixed;
    logic [7:0] r;
    load(32'h0000_00A5, 1);
    bus(1'h1, `MPG_GEOM, `MPG_GEOM_RST);
    arm <= 1'h1;
    bus(1'h1, `MPG_CTRL, 32'h0000_0082);
    for (int i = 0; i < 80 && cap_done !== 1'h1; i++) @(posedge hclk);
    `CHK({cap_done, cap}, 9'h1A5)
    // second row's zero data shows the x^7+x^6+1 run from seed 7f, stream bits 16..23
    repeat (7) @(posedge hclk);
    for (int j = 0; j < 8; j++) begin
      @(negedge hclk);
      r[j] = lane_lsb;
    end
    `CHK(r, 8'h18)
    @(posedge hclk);
    arm <= 1'h0;
    bus(1'h1, `MPG_CTRL, 32'h0000_0000);
  endtask : t_mixed
  // constant 10 symbols show the gray map and polarity; loading must park the lanes
  task t_pam;
    load(32'hAAAA_AAAA, 2);
    bus(1'h1, `MPG_CTRL, 32'h0000_00C1);
    repeat (8) @(posedge hclk);
    bus(1'h0, `MPG_STAT, 32'h0000_0000);
    `CHK(rv[3:2] !== G_PAM, 1'h1)
    chan_combined <= 1'h1;
    // pam4 is only entered from idle, so a run restart picks up the combination
    bus(1'h1, `MPG_CTRL, 32'h0000_0000);
    bus(1'h1, `MPG_CTRL, 32'h0000_00C1);
    repeat (8) @(posedge hclk);
    bus(1'h0, `MPG_STAT, 32'h0000_0000);
    `CHK(rv[3:2], G_PAM)
    for (int k = 0; k < 4; k++) begin
      logic [31:0] c;
      c = 32'h0000_00C1;
      c[5] = k[0];
      c[3] = k[1];
      bus(1'h1, `MPG_CTRL, c);
      repeat (6) @(posedge hclk);
      repeat (3) begin
        @(negedge hclk);
        `CHK(sym, {1'h1, c[5]} ^ {2{c[3]}})
      end
      @(posedge hclk);
    end
    bus(1'h1, `MPG_LOAD, 32'h0000_0001);
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    `CHK({lane_msb, lane_lsb}, 2'h3)
    @(posedge hclk);
    bus(1'h0, `MPG_STAT, 32'h0000_0000);
    `CHK(rv[3:2], G_IDLE)
    bus(1'h1, `MPG_LOAD, 32'h0000_0000);
  endtask : t_pam
  // three restarts from one seed: invert must complement the symbol, gray must map it
  task t_inv;
    logic [1:0] s0;
    for (int k = 0; k < 3; k++) begin
      bus(1'h1, `MPG_CTRL, 32'h0000_0000);
      if (k == 0) bus(1'h1, `MPG_CTRL, 32'h0000_0081);
      else if (k == 1) bus(1'h1, `MPG_CTRL, 32'h0000_0091);
      else bus(1'h1, `MPG_CTRL, 32'h0000_00A1);
      repeat (5) @(posedge hclk);
      @(negedge hclk);
      if (k == 0) s0 = sym;
      else if (k == 1) `CHK(sym, ~s0)
      else `CHK(sym, {s0[1], s0[1] ^ s0[0]})
      @(posedge hclk);
    end
  endtask : t_inv
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    chan_combined = 1'h0;
    arm = 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_regs();
    t_blocks();
    t_mixed();
    t_pam();
    t_inv();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
